// >>> core/pin_mux_regs.svh
/*
 * Pin index map and fixed widths for the port/peripheral pin multiplexer.
 * Assumes it is included by bare name from the package and the top module.
 */
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ****************************************
// pin index map
// ****************************************
`define PIN_COUNT        55
`define PIN_ZIN_IRQ      0
`define PIN_TRIGGER      1
`define PIN_CLK_MON      3
`define PIN_COMPARE      4
`define PIN_PULSE0       8
`define PIN_PORT4        10
`define PIN_PULSE1       10
`define PIN_ASYNC_RX     12
`define PIN_ASYNC_TX     13
`define PIN_ASYNC_CLK    14
`define PIN_SYNC0_RX     15
`define PIN_SYNC0_TX     16
`define PIN_SYNC0_CLK    17
`define PIN_SYNC1_RX     18
`define PIN_SYNC1_TX     19
`define PIN_SYNC1_CLK    20
`define PIN_DAC          21
`define PIN_ANALOG       23
`define PIN_EVT0_CMP4    31
`define PIN_TMR0_CMP5    32
`define PIN_EVT1_CMP6    33
`define PIN_TMR1_CMP7    34
`define PIN_COMMON       35
`define PIN_SEGMENT_HI   39
`define PIN_SEGMENT_MID  47

// ****************************************
// widths
// ****************************************
`define PORT_WIDTH       8
`define SEGMENT_COUNT    24
`define COMMON_COUNT     4
`define SEGMENT_GROUP    4

`endif

// >>> core/pin_mux_pkg.sv
/*
 * Types shared by the pin multiplexer files.
 * Assumes pin_mux_regs.svh is on the include path.
 */
package pin_mux_pkg;
   `include "pin_mux_regs.svh"

   typedef logic [`PIN_COUNT-1:0]     pin_vec_type;
   typedef logic [`PORT_WIDTH-1:0]    port_byte_type;
   typedef logic [`SEGMENT_COUNT-1:0] segment_vec_type;
endpackage

// >>> core/pin_cell.sv
/*
 * One shared pin: selects port or peripheral drive, registers the pad
 * output and enable, and synchronises the pad level with two flip-flops.
 * Assumes a single synchronous active-high reset on the core clock.
 */
`timescale 1ns/100ps
module pin_cell (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_port_data,
   input  wire logic i_port_dir,
   input  wire logic i_func_out,
   input  wire logic i_func_en,
   input  wire logic i_drive_block,
   input  wire logic i_pad_in,
   output logic      o_pad_out,
   output logic      o_pad_oe,
   output logic      o_pad_sync
);
   logic pad_out_reg;
   logic pad_out_next;
   logic pad_oe_reg;
   logic pad_oe_next;
   logic meta_reg;
   logic sync_reg;

   // ****************************************
   // drive select
   // ****************************************
   always_comb begin
      pad_out_next = i_func_en ? i_func_out : i_port_data;
      // an analog use of the pin keeps the digital driver off whatever else asks
      pad_oe_next  = !i_drive_block && (i_func_en || i_port_dir);
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         pad_out_reg <= 1'h0;
         pad_oe_reg  <= 1'h0;
      end else begin
         pad_out_reg <= pad_out_next;
         pad_oe_reg  <= pad_oe_next;
      end
   end

   // ****************************************
   // input synchroniser
   // ****************************************
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_reg <= 1'h0;
         sync_reg <= 1'h0;
      end else begin
         meta_reg <= i_pad_in;
         sync_reg <= meta_reg;
      end
   end

   assign o_pad_out  = pad_out_reg;
   assign o_pad_oe   = pad_oe_reg;
   assign o_pad_sync = sync_reg;
endmodule

// >>> core/pin_mux.sv
/*
 * Port and peripheral pin multiplexer: per-pin drive selection, LCD
 * common/segment versus port choice, analog input and converter output
 * gating, port 4 pull-up control and peripheral input fan-out.
 * Assumes port data/direction and peripheral enables come from registers
 * on the core clock; pad inputs are asynchronous.
 */
`timescale 1ns/100ps
`include "pin_mux_regs.svh"
module pin_mux (
   input  wire logic                       I_CORE_CLK,
   input  wire logic                       I_RESET,
   input  wire pin_mux_pkg::pin_vec_type   I_PORT_DATA,
   input  wire pin_mux_pkg::pin_vec_type   I_PORT_DIR,
   input  wire pin_mux_pkg::pin_vec_type   I_PAD_IN,
   output pin_mux_pkg::pin_vec_type        O_PAD_OUT,
   output pin_mux_pkg::pin_vec_type        O_PAD_OE,
   output pin_mux_pkg::pin_vec_type        O_PORT_IN,
   input  wire logic [7:0]                 I_COMPARE_EVT_OUT,
   input  wire logic [7:0]                 I_COMPARE_OE,
   input  wire logic [3:0]                 I_PULSE_GEN_OUT,
   input  wire logic [3:0]                 I_PULSE_GEN_OE,
   input  wire logic [1:0]                 I_RELOAD_TIMER_OUT,
   input  wire logic [1:0]                 I_RELOAD_TIMER_OE,
   input  wire logic                       I_ASYNC_TX_DATA,
   input  wire logic                       I_ASYNC_TX_OE,
   input  wire logic                       I_ASYNC_SERIAL_CLK,
   input  wire logic                       I_ASYNC_CLK_OE,
   input  wire logic [1:0]                 I_SYNC_SERIAL_TX,
   input  wire logic [1:0]                 I_SYNC_TX_OE,
   input  wire logic [1:0]                 I_SYNC_SERIAL_CLK,
   input  wire logic [1:0]                 I_SYNC_CLK_OE,
   input  wire logic                       I_CLOCK_MONITOR_OUT,
   input  wire logic                       I_CLOCK_MONITOR_OE,
   input  wire pin_mux_pkg::port_byte_type I_PORT4_PULLUP_SETUP,
   output pin_mux_pkg::port_byte_type      O_PORT4_PULLUP_EN,
   input  wire pin_mux_pkg::port_byte_type I_ANALOG_INPUT_ENABLE,
   output pin_mux_pkg::port_byte_type      O_ANALOG_CHANNEL_SEL,
   input  wire logic [1:0]                 I_DAC_OUTPUT_ENABLE,
   output logic [1:0]                      O_DAC_ANALOG_SEL,
   input  wire logic                       I_LCD_COMMON_SEL,
   input  wire logic                       I_LCD_SEGMENT_HI_SEL,
   input  wire logic [1:0]                 I_LCD_SEGMENT_MID_SEL,
   input  wire logic [3:0]                 I_LCD_COMMON,
   input  wire pin_mux_pkg::segment_vec_type I_LCD_SEGMENT,
   output pin_mux_pkg::port_byte_type      O_LCD_SEGMENT_PIN,
   output logic                            O_ASYNC_RX_DATA,
   output logic                            O_ASYNC_SERIAL_CLK_IN,
   output logic [1:0]                      O_SYNC_SERIAL_RX,
   output logic [1:0]                      O_SYNC_SERIAL_CLK_IN,
   output logic [1:0]                      O_RELOAD_TIMER_EVT_IN,
   output logic                            O_CONVERTER_TRIGGER_IN,
   output logic [1:0]                      O_UPDOWN_COUNT_Z_IN,
   output logic                            O_UPDOWN_COUNT_A_IN,
   output logic                            O_UPDOWN_COUNT_B_IN,
   output logic                            O_EXT_IRQ_IN
);
   pin_mux_pkg::pin_vec_type    func_out;
   pin_mux_pkg::pin_vec_type    func_en;
   pin_mux_pkg::pin_vec_type    drive_block;
   pin_mux_pkg::pin_vec_type    pad_sync;
   pin_mux_pkg::pin_vec_type    port_in_reg;
   pin_mux_pkg::pin_vec_type    port_in_next;
   pin_mux_pkg::port_byte_type  pullup_reg;
   pin_mux_pkg::port_byte_type  pullup_next;
   pin_mux_pkg::port_byte_type  analog_sel_reg;
   pin_mux_pkg::port_byte_type  segment_low_reg;
   logic [1:0]                  dac_sel_reg;

   // ****************************************
   // peripheral drive per pin
   // ****************************************
   always_comb begin
      func_out    = {`PIN_COUNT{1'h0}};
      func_en     = {`PIN_COUNT{1'h0}};
      drive_block = {`PIN_COUNT{1'h0}};
      func_out[`PIN_CLK_MON]    = I_CLOCK_MONITOR_OUT;
      func_en[`PIN_CLK_MON]     = I_CLOCK_MONITOR_OE;
      func_out[`PIN_COMPARE+:4] = I_COMPARE_EVT_OUT[3:0];
      func_en[`PIN_COMPARE+:4]  = I_COMPARE_OE[3:0];
      func_out[`PIN_PULSE0+:2]  = I_PULSE_GEN_OUT[1:0];
      func_en[`PIN_PULSE0+:2]   = I_PULSE_GEN_OE[1:0];
      func_out[`PIN_PULSE1+:2]  = I_PULSE_GEN_OUT[3:2];
      func_en[`PIN_PULSE1+:2]   = I_PULSE_GEN_OE[3:2];
      func_out[`PIN_ASYNC_TX]   = I_ASYNC_TX_DATA;
      func_en[`PIN_ASYNC_TX]    = I_ASYNC_TX_OE;
      func_out[`PIN_ASYNC_CLK]  = I_ASYNC_SERIAL_CLK;
      func_en[`PIN_ASYNC_CLK]   = I_ASYNC_CLK_OE;
      func_out[`PIN_SYNC0_TX]   = I_SYNC_SERIAL_TX[0];
      func_en[`PIN_SYNC0_TX]    = I_SYNC_TX_OE[0];
      func_out[`PIN_SYNC0_CLK]  = I_SYNC_SERIAL_CLK[0];
      func_en[`PIN_SYNC0_CLK]   = I_SYNC_CLK_OE[0];
      func_out[`PIN_SYNC1_TX]   = I_SYNC_SERIAL_TX[1];
      func_en[`PIN_SYNC1_TX]    = I_SYNC_TX_OE[1];
      func_out[`PIN_SYNC1_CLK]  = I_SYNC_SERIAL_CLK[1];
      func_en[`PIN_SYNC1_CLK]   = I_SYNC_CLK_OE[1];
      func_out[`PIN_EVT0_CMP4]  = I_COMPARE_EVT_OUT[4];
      func_en[`PIN_EVT0_CMP4]   = I_COMPARE_OE[4];
      func_out[`PIN_EVT1_CMP6]  = I_COMPARE_EVT_OUT[6];
      func_en[`PIN_EVT1_CMP6]   = I_COMPARE_OE[6];
      // timer output has the fixed priority on the two shared pins
      func_out[`PIN_TMR0_CMP5]  = I_RELOAD_TIMER_OE[0] ? I_RELOAD_TIMER_OUT[0]
                                                      : I_COMPARE_EVT_OUT[5];
      func_en[`PIN_TMR0_CMP5]   = I_RELOAD_TIMER_OE[0] || I_COMPARE_OE[5];
      func_out[`PIN_TMR1_CMP7]  = I_RELOAD_TIMER_OE[1] ? I_RELOAD_TIMER_OUT[1]
                                                      : I_COMPARE_EVT_OUT[7];
      func_en[`PIN_TMR1_CMP7]   = I_RELOAD_TIMER_OE[1] || I_COMPARE_OE[7];
      func_out[`PIN_COMMON+:4]  = I_LCD_COMMON;
      func_en[`PIN_COMMON+:4]   = {`COMMON_COUNT{I_LCD_COMMON_SEL}};
      func_out[`PIN_SEGMENT_HI+:8] = I_LCD_SEGMENT[23:16];
      func_en[`PIN_SEGMENT_HI+:8]  = {`PORT_WIDTH{I_LCD_SEGMENT_HI_SEL}};
      func_out[`PIN_SEGMENT_MID+:8] = I_LCD_SEGMENT[15:8];
      func_en[`PIN_SEGMENT_MID+:8]  = {{`SEGMENT_GROUP{I_LCD_SEGMENT_MID_SEL[1]}},
                                       {`SEGMENT_GROUP{I_LCD_SEGMENT_MID_SEL[0]}}};
      // analog use of a pin must not fight a digital driver
      drive_block[`PIN_ANALOG+:8] = I_ANALOG_INPUT_ENABLE;
      drive_block[`PIN_DAC+:2]    = I_DAC_OUTPUT_ENABLE;
   end

   // ****************************************
   // pin cells
   // ****************************************
   for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
      pin_cell u_cell (
         .i_clk         (I_CORE_CLK),
         .i_reset       (I_RESET),
         .i_port_data   (I_PORT_DATA[i]),
         .i_port_dir    (I_PORT_DIR[i]),
         .i_func_out    (func_out[i]),
         .i_func_en     (func_en[i]),
         .i_drive_block (drive_block[i]),
         .i_pad_in      (I_PAD_IN[i]),
         .o_pad_out     (O_PAD_OUT[i]),
         .o_pad_oe      (O_PAD_OE[i]),
         .o_pad_sync    (pad_sync[i])
      );
   end

   // ****************************************
   // port read path and side controls
   // ****************************************
   always_comb begin
      port_in_next = pad_sync;
      port_in_next[`PIN_ANALOG+:8] = pad_sync[`PIN_ANALOG+:8] & ~I_ANALOG_INPUT_ENABLE;
      // a bit counts as driving when either the port or a peripheral owns it
      pullup_next = I_PORT4_PULLUP_SETUP
                    & ~(I_PORT_DIR[`PIN_PORT4+:8] | func_en[`PIN_PORT4+:8]);
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         port_in_reg <= {`PIN_COUNT{1'h0}};
      end else begin
         port_in_reg <= port_in_next;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         pullup_reg     <= 8'h00;
         analog_sel_reg <= 8'h00;
         dac_sel_reg    <= 2'h0;
      end else begin
         pullup_reg     <= pullup_next;
         analog_sel_reg <= I_ANALOG_INPUT_ENABLE;
         dac_sel_reg    <= I_DAC_OUTPUT_ENABLE;
      end
   end

   always_ff @(posedge I_CORE_CLK) begin
      if (I_RESET) begin
         segment_low_reg <= 8'h00;
      end else begin
         segment_low_reg <= I_LCD_SEGMENT[7:0];
      end
   end

   assign O_PORT_IN            = port_in_reg;
   assign O_PORT4_PULLUP_EN    = pullup_reg;
   assign O_ANALOG_CHANNEL_SEL = analog_sel_reg;
   assign O_DAC_ANALOG_SEL     = dac_sel_reg;
   assign O_LCD_SEGMENT_PIN    = segment_low_reg;

   // ****************************************
   // peripheral inputs, always fed from the pad
   // ****************************************
   assign O_ASYNC_RX_DATA        = pad_sync[`PIN_ASYNC_RX];
   assign O_ASYNC_SERIAL_CLK_IN  = pad_sync[`PIN_ASYNC_CLK];
   assign O_SYNC_SERIAL_RX       = {pad_sync[`PIN_SYNC1_RX], pad_sync[`PIN_SYNC0_RX]};
   assign O_SYNC_SERIAL_CLK_IN   = {pad_sync[`PIN_SYNC1_CLK], pad_sync[`PIN_SYNC0_CLK]};
   assign O_RELOAD_TIMER_EVT_IN  = {pad_sync[`PIN_EVT1_CMP6], pad_sync[`PIN_EVT0_CMP4]};
   assign O_CONVERTER_TRIGGER_IN = pad_sync[`PIN_TRIGGER];
   assign O_UPDOWN_COUNT_Z_IN    = {pad_sync[`PIN_SYNC1_CLK], pad_sync[`PIN_ZIN_IRQ]};
   assign O_UPDOWN_COUNT_A_IN    = pad_sync[`PIN_SYNC1_RX];
   assign O_UPDOWN_COUNT_B_IN    = pad_sync[`PIN_SYNC1_TX];
   assign O_EXT_IRQ_IN           = pad_sync[`PIN_ZIN_IRQ];

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RESET);

   sequence pad_irq_held_high;
      I_PAD_IN[`PIN_ZIN_IRQ] [*3];
   endsequence

   a_compare_pin_drive: assert property (I_COMPARE_OE[0] |=> O_PAD_OE[`PIN_COMPARE]
      && O_PAD_OUT[`PIN_COMPARE] == $past(I_COMPARE_EVT_OUT[0]))
      else $error("compare pin not driven by compare channel");
   a_compare_pin_release: assert property (!I_COMPARE_OE[1] |=>
      O_PAD_OUT[`PIN_COMPARE+1] == $past(I_PORT_DATA[`PIN_COMPARE+1])
      && O_PAD_OE[`PIN_COMPARE+1] == $past(I_PORT_DIR[`PIN_COMPARE+1]))
      else $error("compare pin not returned to port");
   a_pulse_gen_drive: assert property (I_PULSE_GEN_OE[2] |=> O_PAD_OE[`PIN_PULSE1]
      && O_PAD_OUT[`PIN_PULSE1] == $past(I_PULSE_GEN_OUT[2]))
      else $error("pulse generator pin wrong");
   a_timer_pin_port: assert property (!I_RELOAD_TIMER_OE[0] && !I_COMPARE_OE[5] |=>
      O_PAD_OUT[`PIN_TMR0_CMP5] == $past(I_PORT_DATA[`PIN_TMR0_CMP5]))
      else $error("timer pin not port when disabled");
   a_timer_over_compare: assert property (I_RELOAD_TIMER_OE[1] && I_COMPARE_OE[7] |=>
      O_PAD_OUT[`PIN_TMR1_CMP7] == $past(I_RELOAD_TIMER_OUT[1]))
      else $error("timer output lost priority");
   a_async_tx_drive: assert property (I_ASYNC_TX_OE |=> O_PAD_OE[`PIN_ASYNC_TX]
      && O_PAD_OUT[`PIN_ASYNC_TX] == $past(I_ASYNC_TX_DATA))
      else $error("async transmit pin wrong");
   a_async_clk_input: assert property (!I_ASYNC_CLK_OE && !I_PORT_DIR[`PIN_ASYNC_CLK]
      |=> !O_PAD_OE[`PIN_ASYNC_CLK])
      else $error("async clock pin driven while input");
   a_sync_pins_drive: assert property (I_SYNC_CLK_OE[1] && !I_SYNC_TX_OE[1] |=>
      O_PAD_OUT[`PIN_SYNC1_CLK] == $past(I_SYNC_SERIAL_CLK[1])
      && O_PAD_OUT[`PIN_SYNC1_TX] == $past(I_PORT_DATA[`PIN_SYNC1_TX]))
      else $error("clocked serial pins wrong");
   a_clock_mon_drive: assert property (I_CLOCK_MONITOR_OE |=> O_PAD_OE[`PIN_CLK_MON]
      && O_PAD_OUT[`PIN_CLK_MON] == $past(I_CLOCK_MONITOR_OUT))
      else $error("clock monitor pin wrong");
   a_pullup_output_off: assert property (I_PORT_DIR[`PIN_PORT4+3] |=>
      !O_PORT4_PULLUP_EN[3])
      else $error("pull-up on while driving");
   a_pullup_input_on: assert property (!I_PORT_DIR[`PIN_PORT4] && !I_PULSE_GEN_OE[2]
      |=> O_PORT4_PULLUP_EN[0] == $past(I_PORT4_PULLUP_SETUP[0]))
      else $error("pull-up ignores setup bit");
   a_analog_input_mask: assert property (I_ANALOG_INPUT_ENABLE[3] |=>
      !O_PORT_IN[`PIN_ANALOG+3] && O_ANALOG_CHANNEL_SEL[3] && !O_PAD_OE[`PIN_ANALOG+3])
      else $error("analog pin leaks to port");
   a_irq_input_follow: assert property (pad_irq_held_high |->
      O_EXT_IRQ_IN && O_UPDOWN_COUNT_Z_IN[0])
      else $error("interrupt input not following pad");
   a_common_pin_drive: assert property (I_LCD_COMMON_SEL |=> O_PAD_OE[`PIN_COMMON+2]
      && O_PAD_OUT[`PIN_COMMON+2] == $past(I_LCD_COMMON[2]))
      else $error("common pin wrong");
   a_segment_mid_group: assert property (I_LCD_SEGMENT_MID_SEL == 2'h2 |=>
      O_PAD_OUT[`PIN_SEGMENT_MID+5] == $past(I_LCD_SEGMENT[13])
      && O_PAD_OUT[`PIN_SEGMENT_MID+1] == $past(I_PORT_DATA[`PIN_SEGMENT_MID+1]))
      else $error("segment group select wrong");
   a_segment_low_pins: assert property (1'h1 |=>
      O_LCD_SEGMENT_PIN == $past(I_LCD_SEGMENT[7:0]))
      else $error("dedicated segment pins wrong");
   a_dac_driver_off: assert property (I_DAC_OUTPUT_ENABLE[0] |=>
      !O_PAD_OE[`PIN_DAC] && O_DAC_ANALOG_SEL[0])
      else $error("digital driver on converter output");
endmodule

// >>> tb/pad_board.sv
/* Board model for the pin multiplexer pads: resolves each pad level.
   Assumes pad drive and enable come straight from the multiplexer. */
`timescale 1ns/100ps
module pad_board (
   input  wire pin_mux_pkg::pin_vec_type   i_pad_out,
   input  wire pin_mux_pkg::pin_vec_type   i_pad_oe,
   input  wire pin_mux_pkg::pin_vec_type   i_ext_val,
   input  wire pin_mux_pkg::pin_vec_type   i_ext_en,
   input  wire pin_mux_pkg::port_byte_type i_pullup_en,
   output pin_mux_pkg::pin_vec_type        o_pad_in
);
   // ****************
   // pad resolution
   // ****************
   always_comb begin
      for (int i = 0; i < 55; i++) begin
         if (i_pad_oe[i]) begin
            o_pad_in[i] = i_pad_out[i];
         end else if (i_ext_en[i]) begin
            // board drives a pad only while the device has released it
            o_pad_in[i] = i_ext_val[i];
         end else if (i >= 10 && i < 18 && i_pullup_en[i-10]) begin
            o_pad_in[i] = 1'b1;
         end else begin
            // floating pad keeps no value, so show the inverse
            o_pad_in[i] = ~i_pad_out[i];
         end
      end
   end
endmodule

// >>> tb/tb.sv
/* Self-checking bench for the pin multiplexer.
   Assumes the board model drives the pad inputs. */
`timescale 1ns/100ps
module tb;
   logic                         I_CORE_CLK, I_RESET;
   pin_mux_pkg::pin_vec_type     I_PORT_DATA, I_PORT_DIR, I_PAD_IN, O_PAD_OUT, O_PAD_OE;
   pin_mux_pkg::pin_vec_type     O_PORT_IN, ext_val, ext_en;
   logic [7:0]                   I_COMPARE_EVT_OUT, I_COMPARE_OE;
   logic [3:0]                   I_PULSE_GEN_OUT, I_PULSE_GEN_OE, I_LCD_COMMON;
   logic [1:0]                   I_RELOAD_TIMER_OUT, I_RELOAD_TIMER_OE, I_SYNC_SERIAL_TX;
   logic [1:0]                   I_SYNC_TX_OE, I_SYNC_SERIAL_CLK, I_SYNC_CLK_OE;
   logic [1:0]                   I_DAC_OUTPUT_ENABLE, O_DAC_ANALOG_SEL, I_LCD_SEGMENT_MID_SEL;
   logic [1:0]                   O_SYNC_SERIAL_RX, O_SYNC_SERIAL_CLK_IN;
   logic [1:0]                   O_RELOAD_TIMER_EVT_IN, O_UPDOWN_COUNT_Z_IN;
   logic                         I_ASYNC_TX_DATA, I_ASYNC_TX_OE, I_ASYNC_SERIAL_CLK;
   logic                         I_ASYNC_CLK_OE, I_CLOCK_MONITOR_OUT, I_CLOCK_MONITOR_OE;
   logic                         I_LCD_COMMON_SEL, I_LCD_SEGMENT_HI_SEL, O_ASYNC_RX_DATA;
   logic                         O_ASYNC_SERIAL_CLK_IN, O_CONVERTER_TRIGGER_IN;
   logic                         O_UPDOWN_COUNT_A_IN, O_UPDOWN_COUNT_B_IN, O_EXT_IRQ_IN;
   pin_mux_pkg::port_byte_type   I_PORT4_PULLUP_SETUP, O_PORT4_PULLUP_EN;
   pin_mux_pkg::port_byte_type   I_ANALOG_INPUT_ENABLE, O_ANALOG_CHANNEL_SEL, O_LCD_SEGMENT_PIN;
   pin_mux_pkg::segment_vec_type I_LCD_SEGMENT;
   int                           fails, samples_checked;
   // pins owned by a peripheral output other than the LCD when enabled
   localparam pin_mux_pkg::pin_vec_type M = 55'h7801B6FF8;
   localparam logic [23:0] SEG = 24'hA5C33C;

   pin_mux u_dut (.*);
   pad_board u_board (.i_pad_out(O_PAD_OUT), .i_pad_oe(O_PAD_OE), .i_ext_val(ext_val),
      .i_ext_en(ext_en), .i_pullup_en(O_PORT4_PULLUP_EN), .o_pad_in(I_PAD_IN));

   // ****************
   // helpers
   // ****************
   initial begin
      I_CORE_CLK = 1'b0;
      forever #10 I_CORE_CLK = ~I_CORE_CLK;
   end
   task step(input int n);
      repeat (n) @(posedge I_CORE_CLK);
      #1;
   endtask
   task chk(input string name, input logic [54:0] seen, input logic [54:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task peri(input logic on, input logic v);
      {I_COMPARE_OE, I_PULSE_GEN_OE, I_RELOAD_TIMER_OE, I_SYNC_TX_OE} = {16{on}};
      {I_SYNC_CLK_OE, I_ASYNC_TX_OE, I_ASYNC_CLK_OE, I_CLOCK_MONITOR_OE} = {5{on}};
      {I_COMPARE_EVT_OUT, I_PULSE_GEN_OUT, I_RELOAD_TIMER_OUT, I_SYNC_SERIAL_TX} = {16{v}};
      {I_SYNC_SERIAL_CLK, I_ASYNC_TX_DATA, I_ASYNC_SERIAL_CLK, I_CLOCK_MONITOR_OUT} = {5{v}};
   endtask
   task idle;
      peri(1'b0, 1'b0);
      {I_PORT_DATA, I_PORT_DIR, ext_val, ext_en} = '0;
      {I_PORT4_PULLUP_SETUP, I_ANALOG_INPUT_ENABLE, I_DAC_OUTPUT_ENABLE} = '0;
      {I_LCD_COMMON_SEL, I_LCD_SEGMENT_HI_SEL, I_LCD_SEGMENT_MID_SEL, I_LCD_COMMON} = '0;
      I_LCD_SEGMENT = '0;
   endtask

   // ****************
   // scenarios
   // ****************
   task t_periph;
      idle();
      I_PORT_DATA = '1;
      I_PORT_DIR = '1;
      step(1);
      chk("port fallback", O_PAD_OUT & O_PAD_OE & M, M);
      peri(1'b1, 1'b0);
      step(1);
      chk("periph low oe", O_PAD_OE & M, M);
      chk("periph low", O_PAD_OUT & M, 55'h0);
      peri(1'b1, 1'b1);
      I_PORT_DIR = '0;
      step(1);
      chk("periph high", O_PAD_OUT & O_PAD_OE & M, M);
      peri(1'b0, 1'b1);
      step(1);
      chk("periph off", O_PAD_OE & M, 55'h0);
   endtask
   task t_priority;
      idle();
      I_COMPARE_OE[5] = 1'b1;
      I_COMPARE_EVT_OUT[5] = 1'b1;
      step(1);
      chk("cmp only", {O_PAD_OE[32], O_PAD_OUT[32]}, 2'b11);
      I_RELOAD_TIMER_OE[0] = 1'b1;
      step(1);
      chk("timer wins low", {O_PAD_OE[32], O_PAD_OUT[32]}, 2'b10);
      I_RELOAD_TIMER_OUT[0] = 1'b1;
      I_COMPARE_EVT_OUT[5] = 1'b0;
      step(1);
      chk("timer wins high", O_PAD_OUT[32], 1'b1);
   endtask
   task t_pullup;
      idle();
      I_PORT4_PULLUP_SETUP = 8'hFF;
      I_PORT_DIR[17:10] = 8'h0F;
      step(1);
      chk("pullup out", O_PORT4_PULLUP_EN, 8'hF0);
      I_PORT4_PULLUP_SETUP = 8'h5A;
      I_PORT_DIR[17:10] = 8'h00;
      step(1);
      chk("pullup in", O_PORT4_PULLUP_EN, 8'h5A);
      I_ASYNC_TX_OE = 1'b1;
      step(1);
      chk("pullup periph", O_PORT4_PULLUP_EN, 8'h52);
   endtask
   task t_analog;
      idle();
      ext_en[30:23] = 8'hFF;
      ext_val[30:23] = 8'hFF;
      I_ANALOG_INPUT_ENABLE = 8'h0F;
      step(4);
      chk("port6 in", O_PORT_IN[30:23], 8'hF0);
      chk("analog sel", O_ANALOG_CHANNEL_SEL, 8'h0F);
   endtask
   task t_fanout;
      idle();
      ext_en = '1;
      step(3);
      ext_val = 55'h80149003;
      step(1);
      chk("irq early", O_EXT_IRQ_IN, 1'b0);
      step(1);
      chk("fanout", {O_EXT_IRQ_IN, O_UPDOWN_COUNT_Z_IN, O_UPDOWN_COUNT_A_IN,
         O_UPDOWN_COUNT_B_IN}, 5'h1E);
      chk("serial inputs", {O_ASYNC_RX_DATA, O_ASYNC_SERIAL_CLK_IN, O_SYNC_SERIAL_RX,
         O_SYNC_SERIAL_CLK_IN, O_RELOAD_TIMER_EVT_IN, O_CONVERTER_TRIGGER_IN}, 9'h173);
      step(1);
      chk("port in", O_PORT_IN, 55'h80149003);
   endtask
   task t_dac;
      idle();
      I_PORT_DIR[22:21] = 2'b11;
      I_PORT_DATA[22:21] = 2'b11;
      I_DAC_OUTPUT_ENABLE = 2'b01;
      step(1);
      chk("dac oe", {O_PAD_OE[22:21], O_DAC_ANALOG_SEL}, 4'h9);
   endtask
   task t_lcd;
      idle();
      {I_PORT_DATA, I_PORT_DIR} = '1;
      {I_LCD_COMMON_SEL, I_LCD_SEGMENT_HI_SEL, I_LCD_SEGMENT_MID_SEL} = 4'hD;
      I_LCD_COMMON = 4'h9;
      I_LCD_SEGMENT = SEG;
      step(1);
      chk("lcd hi", O_PAD_OUT[46:35], {SEG[23:16], 4'h9});
      chk("seg mid", O_PAD_OUT[54:47], {4'hF, SEG[11:8]});
      chk("seg low", O_LCD_SEGMENT_PIN, SEG[7:0]);
      I_PORT_DATA = '0;
      {I_LCD_COMMON_SEL, I_LCD_SEGMENT_HI_SEL, I_LCD_SEGMENT_MID_SEL} = 4'h2;
      step(1);
      chk("com seg port", O_PAD_OUT[46:35], 12'h000);
      chk("seg mid2", O_PAD_OUT[54:47], {SEG[15:12], 4'h0});
   endtask

   task summarize;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      summarize();
   end
   initial begin
      idle();
      I_PORT_DIR = '1;
      I_RESET = 1'b1;
      step(20);
      chk("reset oe", O_PAD_OE, 55'h0);
      I_RESET = 1'b0;
      t_periph();
      t_priority();
      t_pullup();
      t_analog();
      t_fanout();
      t_dac();
      t_lcd();
      summarize();
   end
endmodule
